// ---- verilog/adc_port_pkg.sv ----
// constants and types for the converter parallel control port
package adc_port_pkg;

    // =====================================================
    // clock and timing
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int CONV_TIME_NS    = 3600;
    localparam int ACQ_TIME_NS     = 1000;
    localparam int CONV_TICKS      = 13;
    localparam int EXT_ACQ_TICKS   = 3;
    // longest times: round down, no floor at one cycle
    localparam int INT_TICK_CYCLES = (CONV_TIME_NS * 1000) / (CONV_TICKS * CLK_PERIOD_PS);
    localparam int ACQ_INT_CYCLES  = (ACQ_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int CNT_W           = 8;

    // =====================================================
    // control byte layout
    localparam int CTRL_W           = 8;
    localparam int POWER_MODE_HI    = 7;
    localparam int POWER_MODE_LO    = 6;
    localparam int ACQUIRE_SEL_BIT  = 5;
    localparam int SINGLE_ENDED_BIT = 4;
    localparam int UNIPOLAR_BIT     = 3;
    localparam int CHAN_SEL_MSB     = 2;
    localparam int CHAN_W           = 3;

    // power/clock codes of bits 7:6
    localparam logic [1:0] PWR_SHUTDOWN = 2'h0;
    localparam logic [1:0] PWR_STANDBY  = 2'h1;
    localparam logic [1:0] PWR_INT_CLK  = 2'h2;
    localparam logic [1:0] PWR_EXT_CLK  = 2'h3;

    // =====================================================
    // result
    localparam int RES_W  = 12;
    localparam int NIB_W  = 4;
    localparam logic [RES_W-1:0] SAR_FIRST_TRIAL = 12'h800;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACQ_INT,
        ST_ACQ_EXT,
        ST_CONV
    } conv_state_type;

endpackage : adc_port_pkg

// ---- verilog/adc_port_ctrl.sv ----
// control and readout logic of a 12-bit converter behind a byte-wide parallel port
//
// Contract
// - bits 7:6 written 10 select the internal conversion clock.
// - bits 7:6 written 11 select external clock mode, clock from pin.
// - a power-down request keeps the most recently selected clock mode.
// - after power-up the block starts in external clock mode.
// - internal clock mode completes a conversion in about 3.6 us.
// - chip select high ignores clock, write, read; data bus floats.
// - a write command captures the control byte from data lines 7..0.
// - byte decodes power/clock, acquire mode, single-ended, unipolar, channel.
// - unipolar results straight binary, bipolar results two's complement.
// - high-byte select low drives result bits 7..0 on lines 7..0.
// - high-byte select high drives bits 11..8 low; upper nibble zero or sign.
// - single-ended converts channel numbered by select code against common input.
// - pseudo-differential picks pair by bits 2:1; bit 0 picks positive side.
// - reset enters external clock mode with done output high.
// - power-down keeps the parallel interface alive but performs no conversions.
// - standby wakes on the next write strobe rising edge, ready to convert.
// - power code 00 shutdown, 01 standby, 10 internal, 11 external clock.
// - every conversion takes 13 conversion clock cycles.
// - internal acquisition lasts three external ticks or about 1 us.
// - done output falls on result ready, rises on read or write.
`timescale 1ns/1ps
`default_nettype none

module adc_port_ctrl
    import adc_port_pkg::*;
(
    // clock and reset
    input  wire  logic                              clk,
    input  wire  logic                              sys_rst,
    // host port pins
    input  wire  logic                              cs_n,
    input  wire  logic                              wr_n,
    input  wire  logic                              rd_n,
    input  wire  logic                              high_byte_sel,
    input  wire  logic                              conv_clk_pin,
    input  wire  logic [adc_port_pkg::CTRL_W-1:0]   data_in,
    output var   logic [adc_port_pkg::CTRL_W-1:0]   data_out,
    output var   logic                              data_oe,
    output var   logic                              done_n,
    // analog front end
    input  wire  logic                              cmp_in,
    output var   logic [adc_port_pkg::CHAN_W-1:0]   chan_pos,
    output var   logic [adc_port_pkg::CHAN_W-1:0]   chan_neg,
    output var   logic                              neg_is_common,
    output var   logic                              sample_hold,
    output var   logic [adc_port_pkg::RES_W-1:0]    sar_trial,
    output var   logic                              powered_up
);

    import adc_port_pkg::*;

    // =====================================================
    // state
    typedef struct packed {
        // pin synchronisers, stage 1 feeds stage 2 only
        logic                cs_s1;
        logic                cs_s2;
        logic                wr_s1;
        logic                wr_s2;
        logic                wr_d;
        logic                rd_s1;
        logic                rd_s2;
        logic                rd_d;
        logic                hb_s1;
        logic                hb_s2;
        logic                ck_s1;
        logic                ck_s2;
        logic                ck_d;
        logic                cmp_s1;
        logic                cmp_s2;
        logic [CTRL_W-1:0]   din_s1;
        logic [CTRL_W-1:0]   din_s2;
        // control byte fields
        logic [1:0]          power_mode;
        logic                acquire_select;
        logic                single_ended_sel;
        logic                unipolar_sel;
        logic [CHAN_W-1:0]   chan_sel;
        logic                clock_ext;
        logic                powered;
        // sequencer
        conv_state_type      state;
        logic [CNT_W-1:0]    div_cnt;
        logic [CNT_W-1:0]    step_cnt;
        logic [RES_W-1:0]    trial;
        logic [RES_W-1:0]    bit_mask;
        logic [RES_W-1:0]    result;
        logic                result_uni;
        // registered outputs
        logic                hold;
        logic                done_n;
        logic                data_oe;
        logic [CTRL_W-1:0]   data_out;
        logic [CHAN_W-1:0]   chan_pos;
        logic [CHAN_W-1:0]   chan_neg;
        logic                neg_common;
    } ctrl_state_type;

    ctrl_state_type s_r;
    ctrl_state_type s_nxt;

    localparam logic [CNT_W-1:0] TICK_LAST   = CNT_W'(INT_TICK_CYCLES - 1);
    localparam logic [CNT_W-1:0] ACQ_INT_LAST = CNT_W'(ACQ_INT_CYCLES - 1);
    localparam logic [CNT_W-1:0] ACQ_EXT_LAST = CNT_W'(EXT_ACQ_TICKS - 1);
    localparam logic [CNT_W-1:0] CONV_LAST    = CNT_W'(CONV_TICKS - 1);

    // =====================================================
    // read byte formatting
    function automatic logic [CTRL_W-1:0] read_byte(
        input logic [RES_W-1:0] res,
        input logic             hb,
        input logic             uni
    );
        logic [CTRL_W-1:0] b;
        b = res[CTRL_W-1:0];
        if (hb)
        begin
            b[NIB_W-1:0] = res[RES_W-1:CTRL_W];
            b[CTRL_W-1:NIB_W] = uni ? {NIB_W{1'b0}} : {NIB_W{res[RES_W-1]}};
        end
        return b;
    endfunction : read_byte

    // =====================================================
    // next state
    always_comb
    begin
        logic sel;
        logic wr_rise;
        logic rd_fall;
        logic tick;
        logic conv_done;
        logic [CTRL_W-1:0] cb;
        logic [RES_W-1:0] kept;
        sel       = 1'b0;
        wr_rise   = 1'b0;
        rd_fall   = 1'b0;
        tick      = 1'b0;
        conv_done = 1'b0;
        cb        = '0;
        kept      = '0;
        s_nxt     = s_r;

        s_nxt.cs_s1  = cs_n;
        s_nxt.cs_s2  = s_r.cs_s1;
        s_nxt.wr_s1  = wr_n;
        s_nxt.wr_s2  = s_r.wr_s1;
        s_nxt.wr_d   = s_r.wr_s2;
        s_nxt.rd_s1  = rd_n;
        s_nxt.rd_s2  = s_r.rd_s1;
        s_nxt.rd_d   = s_r.rd_s2;
        s_nxt.hb_s1  = high_byte_sel;
        s_nxt.hb_s2  = s_r.hb_s1;
        s_nxt.ck_s1  = conv_clk_pin;
        s_nxt.ck_s2  = s_r.ck_s1;
        s_nxt.ck_d   = s_r.ck_s2;
        s_nxt.cmp_s1 = cmp_in;
        s_nxt.cmp_s2 = s_r.cmp_s1;
        s_nxt.din_s1 = data_in;
        s_nxt.din_s2 = s_r.din_s1;

        // deselected: clock, write and read all ignored
        sel     = ~s_r.cs_s2;
        wr_rise = sel & s_r.wr_s2 & ~s_r.wr_d;
        rd_fall = sel & ~s_r.rd_s2 & s_r.rd_d;
        cb      = s_r.din_s2;

        // conversion clock tick
        if (s_r.clock_ext)
        begin
            tick = sel & s_r.ck_s2 & ~s_r.ck_d;
            s_nxt.div_cnt = '0;
        end
        else if (s_r.state == ST_IDLE)
        begin
            s_nxt.div_cnt = '0;
        end
        else if (s_r.div_cnt == TICK_LAST)
        begin
            tick = 1'b1;
            s_nxt.div_cnt = '0;
        end
        else
        begin
            s_nxt.div_cnt = s_r.div_cnt + 1'b1;
        end

        // sequencer
        unique case (s_r.state)
            ST_IDLE:
            begin
                s_nxt.hold = 1'b0;
            end
            ST_ACQ_INT:
            begin
                // timed on the system clock when internal, ticks when external
                if (s_r.clock_ext ? tick : 1'b1)
                begin
                    s_nxt.step_cnt = s_r.step_cnt + 1'b1;
                    if (s_r.step_cnt == (s_r.clock_ext ? ACQ_EXT_LAST : ACQ_INT_LAST))
                    begin
                        s_nxt.state    = ST_CONV;
                        s_nxt.step_cnt = '0;
                        s_nxt.hold     = 1'b1;
                        s_nxt.trial    = SAR_FIRST_TRIAL;
                        s_nxt.bit_mask = SAR_FIRST_TRIAL;
                        s_nxt.div_cnt  = '0;
                    end
                end
            end
            ST_ACQ_EXT:
            begin
                // open-ended; the next write with bit 5 clear closes it
                s_nxt.hold = 1'b0;
            end
            ST_CONV:
            begin
                if (tick)
                begin
                    s_nxt.step_cnt = s_r.step_cnt + 1'b1;
                    // tick 0 settles the first trial, ticks 1..12 decide bits
                    if (s_r.step_cnt != '0)
                    begin
                        kept = s_r.cmp_s2 ? s_r.trial : (s_r.trial & ~s_r.bit_mask);
                        s_nxt.bit_mask = s_r.bit_mask >> 1;
                        s_nxt.trial    = kept | (s_r.bit_mask >> 1);
                    end
                    if (s_r.step_cnt == CONV_LAST)
                    begin
                        conv_done      = 1'b1;
                        s_nxt.state    = ST_IDLE;
                        s_nxt.hold     = 1'b0;
                        s_nxt.step_cnt = '0;
                        // front end sees offset binary; bipolar flips the msb
                        s_nxt.result   = s_r.unipolar_sel ? kept :
                                         {~kept[RES_W-1], kept[RES_W-2:0]};
                        s_nxt.result_uni = s_r.unipolar_sel;
                        // a power-down byte takes effect once its conversion ends
                        s_nxt.powered  = s_r.power_mode[1];
                    end
                end
            end
        endcase

        // control byte write
        if (wr_rise)
        begin
            s_nxt.power_mode       = cb[POWER_MODE_HI:POWER_MODE_LO];
            s_nxt.acquire_select   = cb[ACQUIRE_SEL_BIT];
            s_nxt.single_ended_sel = cb[SINGLE_ENDED_BIT];
            s_nxt.unipolar_sel     = cb[UNIPOLAR_BIT];
            s_nxt.chan_sel         = cb[CHAN_SEL_MSB:0];
            unique case (cb[POWER_MODE_HI:POWER_MODE_LO])
                PWR_INT_CLK: s_nxt.clock_ext = 1'b0;
                PWR_EXT_CLK: s_nxt.clock_ext = 1'b1;
                PWR_SHUTDOWN,
                PWR_STANDBY: s_nxt.clock_ext = s_r.clock_ext;
            endcase
            s_nxt.powered  = 1'b1;
            s_nxt.step_cnt = '0;
            s_nxt.div_cnt  = '0;
            if (s_r.state == ST_ACQ_EXT && !cb[ACQUIRE_SEL_BIT])
            begin
                s_nxt.state    = ST_CONV;
                s_nxt.hold     = 1'b1;
                s_nxt.trial    = SAR_FIRST_TRIAL;
                s_nxt.bit_mask = SAR_FIRST_TRIAL;
            end
            else
            begin
                // a write mid-conversion aborts it and re-acquires
                s_nxt.state = cb[ACQUIRE_SEL_BIT] ? ST_ACQ_EXT : ST_ACQ_INT;
                s_nxt.hold  = 1'b0;
            end
        end
        else if (!s_r.powered)
        begin
            s_nxt.state = ST_IDLE;
        end

        // done flag: completion wins over a same-cycle read or write
        if (conv_done)
        begin
            s_nxt.done_n = 1'b0;
        end
        else if (rd_fall || wr_rise)
        begin
            s_nxt.done_n = 1'b1;
        end

        // data bus
        s_nxt.data_oe  = sel & ~s_r.rd_s2;
        s_nxt.data_out = read_byte(s_r.result, s_r.hb_s2, s_r.result_uni);

        // input multiplexer
        s_nxt.chan_pos = s_r.chan_sel;
        if (s_r.single_ended_sel)
        begin
            s_nxt.chan_neg   = s_r.chan_sel;
            s_nxt.neg_common = 1'b1;
        end
        else
        begin
            s_nxt.chan_neg   = {s_r.chan_sel[CHAN_SEL_MSB:1], ~s_r.chan_sel[0]};
            s_nxt.neg_common = 1'b0;
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_r                  <= '0;
            s_r.cs_s1            <= 1'b1;
            s_r.cs_s2            <= 1'b1;
            s_r.wr_s1            <= 1'b1;
            s_r.wr_s2            <= 1'b1;
            s_r.wr_d             <= 1'b1;
            s_r.rd_s1            <= 1'b1;
            s_r.rd_s2            <= 1'b1;
            s_r.rd_d             <= 1'b1;
            s_r.power_mode       <= PWR_EXT_CLK;
            s_r.clock_ext        <= 1'b1;
            s_r.powered          <= 1'b1;
            s_r.single_ended_sel <= 1'b1;
            s_r.unipolar_sel     <= 1'b1;
            s_r.result_uni       <= 1'b1;
            s_r.neg_common       <= 1'b1;
            s_r.state            <= ST_IDLE;
            s_r.done_n           <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // =====================================================
    // outputs
    assign data_out      = s_r.data_out;
    assign data_oe       = s_r.data_oe;
    assign done_n        = s_r.done_n;
    assign chan_pos      = s_r.chan_pos;
    assign chan_neg      = s_r.chan_neg;
    assign neg_is_common = s_r.neg_common;
    assign sample_hold   = s_r.hold;
    assign sar_trial     = s_r.trial;
    assign powered_up    = s_r.powered;

endmodule : adc_port_ctrl

`default_nettype wire

// ---- tb/adc_port_monitor.sv ----
// assertion checker for the converter control port
`timescale 1ns/1ps
`default_nettype none

module adc_port_monitor
    import adc_port_pkg::*;
(
    // clock and reset
    input wire logic                            clk,
    input wire logic                            sys_rst,
    // host port pins
    input wire logic                            cs_n,
    input wire logic                            wr_n,
    input wire logic                            rd_n,
    input wire logic                            high_byte_sel,
    input wire logic [adc_port_pkg::CTRL_W-1:0] data_out,
    input wire logic                            data_oe,
    input wire logic                            done_n,
    // converter state
    input wire logic                            sample_hold,
    input wire logic                            powered_up
);
    // ==================================================
    // hold phase length; wide enough for slow external ticks
    logic [11:0] hold_cnt_r;
    always_ff @(posedge clk)
    begin
        hold_cnt_r <= sample_hold ? hold_cnt_r + 12'h1 : 12'h0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_read;
        (!cs_n && !rd_n)[*2];
    endsequence
    sequence s_write;
        $rose(wr_n) && !cs_n;
    endsequence

    // ==================================================
    // properties
    a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> done_n && !data_oe && powered_up)
        else $error("reset state wrong");
    a_bus_float: assert property (cs_n[*6] |-> !data_oe)
        else $error("bus driven while deselected");
    a_read_drives: assert property ((!cs_n && !rd_n)[*6] |-> data_oe)
        else $error("read not driving bus");
    a_drive_cause: assert property ($rose(data_oe) |-> $past(!rd_n, 3) && $past(!cs_n, 3))
        else $error("bus driven without read");
    a_high_fill: assert property (high_byte_sel[*6] ##0 data_oe
        |-> data_out[7:4] == 4'h0 || data_out[7:4] == {4{data_out[3]}})
        else $error("high nibble fill wrong");
    a_read_clears: assert property (s_read |-> ##[1:6] done_n)
        else $error("read left done low");
    a_write_wakes: assert property (s_write |-> ##[1:6] done_n && powered_up)
        else $error("write did not clear or wake");
    a_conv_length: assert property ($fell(sample_hold) && !done_n
        |-> hold_cnt_r >= 12'h258 && hold_cnt_r <= 12'h578)
        else $error("conversion length wrong");
    a_done_at_end: assert property ($fell(done_n) |-> $fell(sample_hold))
        else $error("done outside conversion end");
    a_no_conv_down: assert property (!powered_up |-> !sample_hold)
        else $error("conversion while powered down");

endmodule : adc_port_monitor

bind adc_port_ctrl adc_port_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .high_byte_sel(high_byte_sel), .data_out(data_out),
    .data_oe(data_oe), .done_n(done_n), .sample_hold(sample_hold), .powered_up(powered_up));

`default_nettype wire

// ---- tb/host_bus_model.sv ----
// host bus, conversion clock and comparator model facing the port
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
(
    // clock
    input  wire logic        clk,
    // device side
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe,
    input  wire logic [11:0] sar_trial,
    input  wire logic [11:0] analog_code,
    output var  logic        cs_n,
    output var  logic        wr_n,
    output var  logic        rd_n,
    output var  logic        high_byte_sel,
    output var  logic        conv_clk_pin,
    output var  logic        cmp_in,
    output logic      [7:0]  data_in
);
    logic [7:0] host_d = 8'h00;
    logic       host_drv = 1'b0;
    int         tick = 0;

    // released bus shows the inverse, not a stale value
    assign data_in = data_oe ? data_out : (host_drv ? host_d : ~host_d);
    // ideal front end; reference counts as settled from the start
    assign cmp_in  = analog_code >= sar_trial;

    initial
    begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        high_byte_sel = 1'b0;
        conv_clk_pin = 1'b0;
    end

    // 2 MHz, 50% duty; parked low while deselected
    always @(negedge clk)
    begin
        tick = cs_n ? 0 : (tick + 1) % 50;
        if (cs_n)
            conv_clk_pin <= 1'b0;
        else if (tick == 0)
            conv_clk_pin <= ~conv_clk_pin;
    end

    task automatic write_byte(input logic [7:0] b, input logic csn);
        @(negedge clk);
        host_d = b;
        host_drv = 1'b1;
        cs_n = csn;
        repeat (4) @(negedge clk);
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        repeat (4) @(negedge clk);
        host_drv = 1'b0;
    endtask : write_byte

    task automatic read_byte(input logic hb, input logic csn, output logic [7:0] v,
                             output bit ok);
        int n;
        @(negedge clk);
        cs_n = csn;
        high_byte_sel = hb;
        repeat (4) @(negedge clk);
        rd_n = 1'b0;
        for (n = 0; n < 16 && data_oe !== 1'b1; n++) @(negedge clk);
        ok = data_oe === 1'b1;
        v = data_out;
        rd_n = 1'b1;
        for (n = 0; n < 16 && data_oe !== 1'b0; n++) @(negedge clk);
        ok = ok && data_oe === 1'b0;
    endtask : read_byte

endmodule : host_bus_model

`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the converter control port
`timescale 1ns/1ps
`default_nettype none

module tb;
    import adc_port_pkg::*;
    // ==================================================
    // signals; windows allow for sync delay and tick phase
    localparam int INT_LO = 840, INT_HI = 960, EXT_LO = 1400, EXT_HI = 1750;
    logic clk, sys_rst, cs_n, wr_n, rd_n, high_byte_sel, conv_clk_pin, cmp_in;
    logic data_oe, done_n, neg_is_common, sample_hold, powered_up;
    logic [7:0]  data_in, data_out, c, v;
    logic [2:0]  chan_pos, chan_neg;
    logic [11:0] sar_trial, analog_code, r;
    int          errors, n_tests, i, n;
    bit          ok;
    // control byte, analog code, expected result
    logic [31:0] rows [8] = '{32'h98ABCABC, 32'h91123923, 32'h8AFFFFFF, 32'h83000800,
                             32'hDC555555, 32'hD5F0F70F, 32'hCE001001, 32'hC77FFFFF};

    adc_port_ctrl dut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .high_byte_sel(high_byte_sel), .conv_clk_pin(conv_clk_pin), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .done_n(done_n), .cmp_in(cmp_in),
        .chan_pos(chan_pos), .chan_neg(chan_neg), .neg_is_common(neg_is_common),
        .sample_hold(sample_hold), .sar_trial(sar_trial), .powered_up(powered_up));
    host_bus_model u_host (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .sar_trial(sar_trial), .analog_code(analog_code), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .high_byte_sel(high_byte_sel), .conv_clk_pin(conv_clk_pin),
        .cmp_in(cmp_in), .data_in(data_in));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==================================================
    // tasks
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [11:0] seen, input logic [11:0] want, input string what);
        n_tests++;
        if (seen !== want)
        begin
            errors++;
            $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check

    task automatic conv(input logic [7:0] b, input int lo, input int hi);
        u_host.write_byte(b, 1'b0);
        for (n = 0; n < 3000 && done_n !== 1'b0; n++) @(negedge clk);
        if (n >= 3000)
        begin
            check(done_n, 12'h0, "done timeout");
            end_of_test();
        end
        check(n >= lo && n <= hi, 12'h1, "conversion time");
        repeat (2) @(negedge clk);
    endtask : conv

    task automatic rd_both(input logic uni, input logic [11:0] res);
        u_host.read_byte(1'b1, 1'b0, v, ok);
        check(ok, 12'h1, "read handshake");
        check(v, {uni ? 4'h0 : {4{res[11]}}, res[11:8]}, "high byte");
        check(done_n, 12'h1, "done after read");
        u_host.read_byte(1'b0, 1'b0, v, ok);
        check(ok, 12'h1, "read handshake");
        check(v, res[7:0], "low byte");
    endtask : rd_both

    // ==================================================
    // sequence
    initial
    begin
        sys_rst = 1'b1;
        analog_code = 12'h000;
        errors = 0;
        n_tests = 0;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        check({done_n, data_oe, powered_up}, 12'h5, "power-on state");
        repeat (2000) @(negedge clk);
        for (i = 0; i < 8; i++)
        begin
            {c, analog_code, r} = rows[i];
            conv(c, c[6] ? EXT_LO : INT_LO, c[6] ? EXT_HI : INT_HI);
            check(chan_pos, c[2:0], "positive channel");
            check(neg_is_common, c[4], "common input");
            if (!c[4]) check(chan_neg, c[2:0] ^ 3'h1, "negative channel");
            rd_both(c[3], r);
            $display("row %0d done", i);
        end
        analog_code = 12'h3C5;
        conv(8'h98, INT_LO, INT_HI);
        conv(8'h18, INT_LO, INT_HI);
        check(powered_up, 12'h0, "shutdown");
        rd_both(1'b1, analog_code);
        repeat (500) @(negedge clk);
        check(done_n, 12'h1, "idle while down");
        conv(8'h59, INT_LO, INT_HI);
        check(powered_up, 12'h0, "standby");
        conv(8'hD8, EXT_LO, EXT_HI);
        check(powered_up, 12'h1, "normal");
        rd_both(1'b1, analog_code);
        $display("power modes done");
        u_host.write_byte(8'hF8, 1'b0);
        repeat (2000) @(negedge clk);
        check({done_n, sample_hold}, 12'h2, "held in acquisition");
        rd_both(1'b1, analog_code);
        conv(8'hD8, 1150, 1400);
        rd_both(1'b1, analog_code);
        $display("external acquisition done");
        conv(8'h98, INT_LO, INT_HI);
        u_host.write_byte(8'h18, 1'b1);
        u_host.read_byte(1'b0, 1'b1, v, ok);
        check(ok, 12'h0, "bus floating");
        check({done_n, powered_up}, 12'h1, "strobes ignored");
        rd_both(1'b1, analog_code);
        $display("chip select done");
        u_host.write_byte(8'h98, 1'b0);
        repeat (300) @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        check({done_n, data_oe, sample_hold, powered_up}, 12'h9, "mid-run reset");
        conv(8'h18, EXT_LO, EXT_HI);
        $display("reset done");
        end_of_test();
    end

endmodule : tb

`default_nettype wire
